//--- hw/bt_map.svh
`ifndef BT_MAP_SVH
`define BT_MAP_SVH
`define BT_OFF_RELOAD     12'h000
`define BT_OFF_COUNT      12'h004
`define BT_OFF_FILTER     12'h00C
`define BT_OFF_CONTROL    12'h010
`define BT_OFF_IRQ_EN     12'h014
`define BT_OFF_STATUS     12'h018
`define BT_OFF_CLEAR      12'h01C
`define BT_RELOAD_RESET   16'hFFFF
`define BT_CLEAR_READ     32'h0000_0007
`define BT_CTL_RUN        0
`define BT_CTL_MODE_LO    1
`define BT_CTL_MODE_HI    2
`define BT_CTL_TRS        3
`define BT_CTL_POL        4
`define BT_CTL_SINGLE     5
`define BT_CTL_TOGGLE_OUTPUT_ENABLE      6
`define BT_CTL_DIV_LO     7
`define BT_CTL_DIV_HI     10
`define BT_CTL_ACT_LO     11
`define BT_CTL_ACT_HI     14
`define BT_FLT_LO         4
`define BT_FLT_HI         6
`define BT_FLAG_TOP       2
`define BT_FLAG_TRIG      1
`define BT_FLAG_OVF       0
`endif

//--- hw/bt_pkg.sv
package bt_pkg;
  typedef enum logic [1:0] {
    BT_MODE_TIMER,
    BT_MODE_COUNTER,
    BT_MODE_TRIGGER,
    BT_MODE_GATED
  } bt_mode_type;
endpackage

//--- hw/bt_basic_timer.sv
`timescale 1ns/1ns
`include "bt_map.svh"
module bt_basic_timer
  import bt_pkg::*;
#(
  parameter int WIDTH = 16
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_trigger_pin,
  input  wire logic        cascade_trigger,
  output logic             toggle_out_true,
  output logic             toggle_out_inverted,
  output logic             irq
);

  logic [WIDTH-1:0] reload_q, reload_d;
  logic [WIDTH-1:0] count_q, count_d;
  logic [2:0]       filter_q, filter_d;
  logic [14:0]      ctl_q, ctl_d;
  logic [2:0]       ien_q, ien_d;
  logic [2:0]       flag_q, flag_d;
  logic [14:0]      pre_q, pre_d;
  logic             armed_q, armed_d;
  logic             tog_q, tog_d;
  logic             src_q, src_d;
  logic [3:0]       fdiv_q, fdiv_d;
  logic [2:0]       fcnt_q, fcnt_d;
  logic             fsamp_q, fsamp_d;
  logic             fout_q, fout_d;

  logic             wr;
  logic             rd_ok;
  logic             run;
  logic [3:0]       div_sel;
  logic [3:0]       div_act;
  logic [14:0]      pre_mask;
  logic             tick;
  logic             pin_lvl;
  logic             trig_raw;
  logic             trig_edge;
  logic             gate_ok;
  logic             step;
  logic             wrap;
  logic             top;
  logic             start;
  logic             samp_en;
  logic [2:0]       need;
  bt_mode_type      mode;

  assign wr      = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign run     = ctl_q[`BT_CTL_RUN];
  assign div_sel = ctl_q[`BT_CTL_DIV_HI:`BT_CTL_DIV_LO];
  assign div_act = ctl_q[`BT_CTL_ACT_HI:`BT_CTL_ACT_LO];
  assign mode    = bt_mode_type'(ctl_q[`BT_CTL_MODE_HI:`BT_CTL_MODE_LO]);

  // filter: sample-rate divider and needed run length
  always_comb
  begin
    unique case (filter_q[2:1])
      2'b10:   samp_en = (fdiv_q[1:0] == 2'h3);
      2'b11:   samp_en = (fdiv_q == 4'hF);
      default: samp_en = 1'b1;
    endcase
    unique case (filter_q)
      3'h1:    need = 3'h2;
      3'h2:    need = 3'h4;
      3'h4:    need = 3'h4;
      3'h6:    need = 3'h4;
      default: need = 3'h6;
    endcase
  end

  always_comb
  begin
    fdiv_d  = fdiv_q + 4'h1;
    fsamp_d = fsamp_q;
    fcnt_d  = fcnt_q;
    fout_d  = fout_q;
    if (samp_en)
    begin
      fsamp_d = external_trigger_pin;
      if (external_trigger_pin == fout_q)
        fcnt_d = 3'h0;
      else if (fsamp_q == external_trigger_pin)
      begin
        // first sample already counted by fsamp_q, so compare need-1
        if (fcnt_q + 3'h2 >= need)
        begin
          fout_d = external_trigger_pin;
          fcnt_d = 3'h0;
        end
        else
          fcnt_d = fcnt_q + 3'h1;
      end
      else
        fcnt_d = 3'h0;
    end
  end

  assign pin_lvl  = (filter_q == 3'h0) ? external_trigger_pin : fout_q;
  // polarity folded in so both edge and level detection see active-high
  assign trig_raw = ctl_q[`BT_CTL_TRS] ? cascade_trigger
                                       : (pin_lvl ^ ctl_q[`BT_CTL_POL]);
  assign trig_edge = trig_raw && !src_q;
  assign gate_ok   = pin_lvl ^ ctl_q[`BT_CTL_POL];
  assign src_d     = trig_raw;

  // prescaler: tick when low k bits of free counter all ones
  assign pre_mask = 15'(({15'h0, 1'b1} << div_act) - 16'h1);
  assign tick     = ((pre_q & pre_mask) == pre_mask);

  always_comb
  begin
    unique case (mode)
      BT_MODE_TIMER:   step = tick;
      BT_MODE_COUNTER: step = trig_edge;
      BT_MODE_TRIGGER: step = tick && armed_q;
      BT_MODE_GATED:   step = tick && gate_ok;
    endcase
    step = step && run;
  end

  assign wrap  = step && (count_q >= reload_q);
  assign top   = step && (count_q == {WIDTH{1'b1}});
  assign start = wr && (paddr == `BT_OFF_CONTROL) && pwdata[`BT_CTL_RUN] && !run;

  always_comb
  begin
    pre_d   = (run && !start) ? pre_q + 15'h1 : 15'h0;
    armed_d = armed_q;
    if (!run || mode != BT_MODE_TRIGGER)
      armed_d = 1'b0;
    else if (trig_edge)
      armed_d = 1'b1;
    count_d = count_q;
    tog_d   = tog_q;
    if (wrap)
    begin
      count_d = '0;
      tog_d   = !tog_q;
    end
    else if (step)
      count_d = count_q + WIDTH'(1);
    // software write wins over a count step in the same cycle
    if (wr && (paddr == `BT_OFF_COUNT))
      count_d = pwdata[WIDTH-1:0];
  end

  // register write path and hardware side effects
  always_comb
  begin
    reload_d = reload_q;
    filter_d = filter_q;
    ctl_d    = ctl_q;
    ien_d    = ien_q;
    flag_d   = flag_q;
    if (wr)
    begin
      unique case (paddr)
        `BT_OFF_RELOAD:  reload_d = pwdata[WIDTH-1:0];
        `BT_OFF_FILTER:  filter_d = pwdata[`BT_FLT_HI:`BT_FLT_LO];
        `BT_OFF_CONTROL: ctl_d[10:0] = pwdata[10:0];
        `BT_OFF_IRQ_EN:  ien_d    = pwdata[2:0];
        `BT_OFF_CLEAR:   flag_d   = flag_q & pwdata[2:0];
        default:         ;
      endcase
    end
    if (wrap || start)
      ctl_d[`BT_CTL_ACT_HI:`BT_CTL_ACT_LO] = start ? pwdata[`BT_CTL_DIV_HI:`BT_CTL_DIV_LO]
                                                   : div_sel;
    if (wrap && ctl_q[`BT_CTL_SINGLE])
      ctl_d[`BT_CTL_RUN] = 1'b0;
    // set wins over a clear in the same cycle
    if (wrap)
      flag_d[`BT_FLAG_OVF] = 1'b1;
    if (top)
      flag_d[`BT_FLAG_TOP] = 1'b1;
    if (run && trig_edge && (mode == BT_MODE_TRIGGER || mode == BT_MODE_COUNTER))
      flag_d[`BT_FLAG_TRIG] = 1'b1;
  end

  always_comb
  begin
    rd_ok = 1'b1;
    unique case (paddr)
      `BT_OFF_RELOAD:  prdata = {{(32-WIDTH){1'b0}}, reload_q};
      `BT_OFF_COUNT:   prdata = {{(32-WIDTH){1'b0}}, count_q};
      `BT_OFF_FILTER:  prdata = {25'h0, filter_q, 4'h0};
      `BT_OFF_CONTROL: prdata = {17'h0, ctl_q};
      `BT_OFF_IRQ_EN:  prdata = {29'h0, ien_q};
      `BT_OFF_STATUS:  prdata = {29'h0, flag_q};
      `BT_OFF_CLEAR:   prdata = `BT_CLEAR_READ;
      default:
      begin
        prdata = 32'h0;
        rd_ok  = 1'b0;
      end
    endcase
  end

  assign pslverr = psel && penable && !rd_ok;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reload_q <= `BT_RELOAD_RESET;
      count_q  <= '0;
      filter_q <= 3'h0;
      ctl_q    <= 15'h0;
      ien_q    <= 3'h0;
      flag_q   <= 3'h0;
      pre_q    <= 15'h0;
      armed_q  <= 1'b0;
      tog_q    <= 1'b0;
      src_q    <= 1'b0;
      fdiv_q   <= 4'h0;
      fcnt_q   <= 3'h0;
      fsamp_q  <= 1'b0;
      fout_q   <= 1'b0;
    end
    else
    begin
      reload_q <= reload_d;
      count_q  <= count_d;
      filter_q <= filter_d;
      ctl_q    <= ctl_d;
      ien_q    <= ien_d;
      flag_q   <= flag_d;
      pre_q    <= pre_d;
      armed_q  <= armed_d;
      tog_q    <= tog_d;
      src_q    <= src_d;
      fdiv_q   <= fdiv_d;
      fcnt_q   <= fcnt_d;
      fsamp_q  <= fsamp_d;
      fout_q   <= fout_d;
    end
  end

  assign toggle_out_true     = ctl_q[`BT_CTL_TOGGLE_OUTPUT_ENABLE] && tog_q;
  assign toggle_out_inverted = ctl_q[`BT_CTL_TOGGLE_OUTPUT_ENABLE] && !tog_q;
  assign irq                 = |(flag_q & ien_q);

endmodule

//--- verification/bt_trig_src.sv
`timescale 1ns/1ns
module bt_trig_src (
  input  wire logic pclk,
  input  wire logic pin_req,
  input  wire logic casc_req,
  output logic      external_trigger_pin,
  output logic      cascade_trigger
);
  // launched after the edge, as from an upstream synchroniser
  always_ff @(posedge pclk)
  begin
    external_trigger_pin <= pin_req;
    cascade_trigger      <= casc_req;
  end
endmodule

//--- verification/bt_basic_timer_monitor.sv
`timescale 1ns/1ns
module bt_basic_timer_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        toggle_out_true,
  input wire logic        toggle_out_inverted,
  input wire logic        irq
);
  logic       rd;
  logic [2:0] ien_q;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  assign rd = psel && penable && !pwrite;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ien_q <= 3'h0;
    else if (psel && penable && pwrite && paddr == 12'h014)
      ien_q <= pwdata[2:0];
  end
  a_tog_exclusive: assert property (!(toggle_out_true && toggle_out_inverted))
    else $error("toggles both high");
  a_tog_enable: assert property (rd && paddr == 12'h010 |-> prdata[6] == (toggle_out_true | toggle_out_inverted))
    else $error("toggle enable mismatch");
  a_irq_masked: assert property (ien_q == 3'h0 |-> !irq)
    else $error("irq while masked");
  a_irq_flags: assert property (rd && paddr == 12'h018 |-> irq == |(prdata[2:0] & ien_q))
    else $error("irq not from flags");
  a_status_upper: assert property (rd && paddr == 12'h018 |-> prdata[31:3] == 29'h0)
    else $error("status upper set");
  a_clear_ones: assert property (rd && paddr == 12'h01C |-> prdata == 32'h0000_0007)
    else $error("clear not ones");
  a_enable_read: assert property (rd && paddr == 12'h014 |-> prdata == {29'h0, ien_q})
    else $error("enable readback");
  a_ctl_upper: assert property (rd && paddr == 12'h010 |-> prdata[31:15] == 17'h0)
    else $error("control upper set");
endmodule
bind bt_basic_timer bt_basic_timer_monitor bt_basic_timer_monitor_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .toggle_out_true(toggle_out_true),
  .toggle_out_inverted(toggle_out_inverted), .irq(irq));

//--- verification/bt_basic_timer_tb.sv
`timescale 1ns/1ns
module bt_basic_timer_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pin_req = 1'b0;
  logic        casc_req = 1'b0;
  logic        pin;
  logic        casc;
  logic        irq;
  logic        tout_t;
  logic        tout_i;
  logic [31:0] hold;
  logic [31:0] rd;
  logic        rdy;
  int          failures = 0;
  int          comparisons = 0;
  int          cycles = 0;
  always #4 pclk = ~pclk;
  bt_trig_src bt_trig_src_inst (.pclk(pclk), .pin_req(pin_req), .casc_req(casc_req),
    .external_trigger_pin(pin), .cascade_trigger(casc));
  bt_basic_timer bt_basic_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(), .external_trigger_pin(pin), .cascade_trigger(casc),
    .toggle_out_true(tout_t), .toggle_out_inverted(tout_i), .irq(irq));
  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // read before the edge's updates land, so these are the sampled values
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      rdy = pready;
      rd = prdata;
    end
    while (rdy !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(rd, e);
  endtask
  task automatic flip(input logic on_pin);
    @(posedge pclk);
    if (on_pin)
      pin_req <= ~pin_req;
    else
      casc_req <= ~casc_req;
    repeat (8) @(posedge pclk);
  endtask
  task automatic start(input logic [31:0] ctl);
    bus(12'h010, 1'b1, 32'h0);
    bus(12'h004, 1'b1, 32'h0);
    bus(12'h010, 1'b1, ctl);
  endtask
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rchk(12'h000, 32'h0000_FFFF);
    rchk(12'h01C, 32'h0000_0007);
    rchk(12'h008, 32'h0);
    bus(12'h014, 1'b1, 32'h7);
    rchk(12'h014, 32'h7);
    bus(12'h014, 1'b1, 32'h0);
    $display("registers done");
    bus(12'h000, 1'b1, 32'h0000_0028);
    start(32'h0000_00E1);
    rchk(12'h010, 32'h0000_08E1);
    bus(12'h010, 1'b1, 32'h0000_01E1);
    repeat (60)
    begin
      bus(12'h018, 1'b0, 32'h0);
      if (rd[0] === 1'b1)
        break;
    end
    chk(rd, 32'h1);
    chk({30'h0, tout_t, tout_i}, 32'h2);
    bus(12'h014, 1'b1, 32'h1);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h1);
    bus(12'h014, 1'b1, 32'h0);
    rchk(12'h010, 32'h0000_19E0);
    rchk(12'h004, 32'h0);
    bus(12'h01C, 1'b1, 32'h7);
    rchk(12'h018, 32'h1);
    bus(12'h01C, 1'b1, 32'h6);
    rchk(12'h018, 32'h0);
    $display("single shot done");
    start(32'h0000_000B);
    repeat (6) flip(1'b0);
    repeat (2) flip(1'b1);
    rchk(12'h004, 32'h3);
    rchk(12'h018, 32'h2);
    $display("counter done");
    start(32'h0000_0007);
    rchk(12'h004, 32'h0);
    flip(1'b1);
    repeat (12) @(posedge pclk);
    flip(1'b1);
    bus(12'h004, 1'b0, 32'h0);
    chk({31'h0, rd != 32'h0}, 32'h1);
    rchk(12'h004, rd);
    $display("gated done");
    start(32'h0000_000D);
    rchk(12'h004, 32'h0);
    repeat (2) flip(1'b0);
    bus(12'h004, 1'b0, 32'h0);
    chk({31'h0, rd != 32'h0}, 32'h1);
    $display("trigger done");
    bus(12'h00C, 1'b1, 32'h0000_0010);
    start(32'h0000_0017);
    flip(1'b1);
    bus(12'h004, 1'b0, 32'h0);
    hold = rd;
    chk({31'h0, hold != 32'h0}, 32'h1);
    @(posedge pclk);
    pin_req <= 1'b0;
    @(posedge pclk);
    pin_req <= 1'b1;
    repeat (8) @(posedge pclk);
    rchk(12'h004, hold);
    bus(12'h010, 1'b1, 32'h0);
    $display("filter done");
    results();
  end
endmodule
